// >>> bench/pmc_host_model.sv
// far-side host model issuing slave-port buffer accesses
// assumes the bench calls access() just after a clock edge
module pmc_host_model
   import pmc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic [1:0] port_mode_r,
   output logic            slave_access,
   output logic [1:0]      slave_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      slave_access = 1'b0;
      slave_addr = 2'h0;
   end
   // the host touches buffers only while the port is a slave; its address
   // lines are not held afterwards, so the inverse is shown
   task automatic access(input logic [1:0] a, input int dly);
      repeat (dly) @(posedge core_clk);
      if (port_mode_r[1] == 1'b0) begin
         slave_access <= 1'b1;
         slave_addr <= a;
         @(posedge core_clk);
         slave_access <= 1'b0;
         slave_addr <= ~a;
      end
   endtask
endmodule

// >>> bench/pmc_mode_ctrl_monitor.sv
// assertions for the port mode control block
// assumes binding onto pmc_mode_ctrl, one clock domain
module pmc_mode_ctrl_monitor
   import pmc_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset_n,
   // register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // port side
   input wire logic        slave_access,
   input wire logic [1:0]  slave_addr,
   input wire logic [1:0]  port_mode_r,
   input wire logic        master_mode_r,
   input wire logic        strobe_active_r,
   input wire logic        byte_high_r,
   input wire logic [10:0] port_address_r,
   input wire logic        buf_step_r,
   input wire logic        irq_r,
   input wire logic        cpu_stall_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------------------------------------------
   // shadow mode word, rebuilt from bus traffic
   // --------------------------------------------------------
   logic [7:0]  awa_r, ara_r;
   logic [14:0] wd_r, sh_r;
   logic [1:0]  ws_r;
   logic        bv_r;
   logic [4:0]  run_r;
   // the shadow lags the design by one cycle, so the write response cycle is excluded
   wire settled = !s_axi_bvalid;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {awa_r, ara_r, wd_r, sh_r, ws_r, bv_r, run_r} <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) awa_r <= s_axi_awaddr;
         if (s_axi_arvalid && s_axi_arready) ara_r <= s_axi_araddr;
         if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[14:0];
         if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[1:0];
         bv_r <= s_axi_bvalid;
         if (s_axi_bvalid && !bv_r && awa_r == PMC_MODE_OFS && ws_r[0]) sh_r[7:0] <= wd_r[7:0];
         if (s_axi_bvalid && !bv_r && awa_r == PMC_MODE_OFS && ws_r[1]) sh_r[14:8] <= wd_r[14:8];
         run_r <= strobe_active_r ? run_r + 5'h01 : 5'h00;
      end
   end
   // --------------------------------------------------------
   // properties
   // --------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_buf3_hit;
      slave_access && slave_addr == PMC_BUF3_ADDR && !port_mode_r[1] && settled;
   endsequence
   sequence s_buf3_armed;
      sh_r[14:13] == PMC_IRQ_BUF3;
   endsequence
   a_mode_field: assert property (settled |-> port_mode_r == sh_r[9:8])
      else $error("port mode differs from written field");
   a_master_flag: assert property (settled |-> master_mode_r == sh_r[9])
      else $error("master flag wrong for mode");
   a_mode_readback: assert property (s_axi_rvalid && ara_r == 8'h00 |-> s_axi_rdata[14:0] == sh_r)
      else $error("mode word read back wrong");
   a_busy_master: assert property (s_axi_rvalid && ara_r == 8'h00 && s_axi_rdata[15] |-> master_mode_r)
      else $error("busy read outside master mode");
   a_irq_quiet: assert property (settled && sh_r[14:13] == PMC_IRQ_NONE |-> !irq_r)
      else $error("interrupt with interrupts off");
   a_stall_mode: assert property (settled && cpu_stall_r |-> sh_r[14:13] == PMC_IRQ_STALL)
      else $error("stall outside stall mode");
   a_buf3_irq: assert property (s_buf3_hit and s_buf3_armed |-> ##[1:3] irq_r)
      else $error("no interrupt on buffer 3 access");
   a_buf_step: assert property (settled && buf_step_r |-> sh_r[12:11] == PMC_STEP_BUF)
      else $error("buffer step in wrong step mode");
   a_addr_hold: assert property (sh_r[12:11] == PMC_STEP_NONE |=> $stable(port_address_r))
      else $error("address moved with stepping off");
   a_strobe_len: assert property ($fell(strobe_active_r) |-> run_r == sh_r[5:2] + 5'h01)
      else $error("strobe length wrong");
   a_wide_byte: assert property (settled && byte_high_r |-> sh_r[10])
      else $error("second byte in narrow mode");
endmodule

bind pmc_mode_ctrl pmc_mode_ctrl_monitor i_pmc_mode_ctrl_monitor (.*);

// >>> bench/pmc_mode_ctrl_test.sv
// self-checking bench for the port mode control block
// assumes the package, design, checker and host model compile first
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %0h got %0h", n, e, v); end end
module pmc_mode_ctrl_test
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------------------------------------------
   // signals
   // --------------------------------------------------------
   logic        core_clk, reset_n, sq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, bw;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, slave_addr, port_mode_r, rs;
   logic        slave_access, master_mode_r, strobe_active_r, byte_high_r, addr_phase_r;
   logic        buf_step_r, irq_r, cpu_stall_r;
   logic [10:0] port_address_r;
   int          error_cnt, checked, cyc, nap, nirq, nstall, nbs, nbh, t_ap, t_sr, t_sf, hg;
   pmc_mode_ctrl i_pmc_mode_ctrl (.*);
   pmc_host_model i_pmc_host_model (.*);
   always #5 core_clk = ~core_clk;
   // --------------------------------------------------------
   // event log and hang guard
   // --------------------------------------------------------
   always @(posedge core_clk) begin
      cyc++;
      if (addr_phase_r === 1'b1) begin nap++; t_ap = cyc; hg = cyc - t_sf; end
      if (strobe_active_r === 1'b1 && !sq) t_sr = cyc;
      if (strobe_active_r === 1'b0 && sq) t_sf = cyc;
      sq = (strobe_active_r === 1'b1);
      nirq += int'(irq_r === 1'b1);
      nstall += int'(cpu_stall_r === 1'b1);
      nbs += int'(buf_step_r === 1'b1);
      nbh += int'(byte_high_r === 1'b1);
      if (cyc == 20000) begin error_cnt++; finish_test(); end
   end
   task automatic finish_test();
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   function automatic logic [15:0] cfg(input logic [1:0] ir, st, input logic wd,
         input logic [1:0] pm, sw, input logic [3:0] mw, input logic [1:0] hw);
      return {1'b0, ir, st, wd, pm, sw, mw, hw};
   endfunction
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      rs = 2'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin rs = s_axi_bresp; s_axi_bready <= 1'b0; break; end
      end
      `CHK("write answer", 1'b1, n < 100)
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      rs = 2'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin d = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 1'b0; break; end
      end
      `CHK("read answer", 1'b1, n < 100)
   endtask
   // one data access: program, start, read mode word early, poll until idle
   task automatic xfer(input logic [15:0] m);
      logic [31:0] d;
      axw(PMC_MODE_OFS, {16'h0000, m}, 4'h3);
      {nap, nirq, nstall, nbs, nbh} = '0;
      axw(PMC_CMD_OFS, 32'h0000_0001, 4'hF);
      axr(PMC_MODE_OFS, bw);
      d = 32'h2;
      for (int n = 0; n < 40 && d[1] !== 1'b0; n++) axr(PMC_STAT_OFS, d);
      `CHK("transfer end", 1'b0, d[1])
      repeat (4) @(posedge core_clk);
   endtask
   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   task automatic t_regs();
      `CHK("mode pins", 2'h0, port_mode_r)
      axr(PMC_MODE_OFS, bw);
      `CHK("mode reset", PMC_MODE_RST, bw[15:0])
      axw(PMC_MODE_OFS, 32'h0000_FFFF, 4'hF);
      axr(PMC_MODE_OFS, bw);
      `CHK("busy read only", 16'h7FFF, bw[15:0])
      axw(PMC_MODE_OFS, 32'h0000_0000, 4'h1);
      axr(PMC_MODE_OFS, bw);
      `CHK("low lane", 16'h7F00, bw[15:0])
      for (int k = 0; k < 4; k++) begin
         axw(PMC_MODE_OFS, {22'h0, k[1:0], 8'h00}, 4'h3);
         // mode outputs are registered one edge after the write lands
         @(posedge core_clk);
         `CHK("port mode", k[1:0], port_mode_r)
         `CHK("master flag", k[1], master_mode_r)
      end
      axw(8'h0C, 32'h0000_0001, 4'hF);
      `CHK("bad write", PMC_RESP_SLVERR, rs)
      axr(8'h0C, bw);
      `CHK("bad read", PMC_RESP_SLVERR, rs)
      `CHK("mode kept", 2'h3, port_mode_r)
   endtask
   // timing is compared against a base setting, so fixed pipeline offsets cancel
   task automatic t_timing();
      int gs, gh;
      xfer(cfg(0, 0, 1, PMC_PM_MASTER1, 0, 1, 0));
      gs = t_sr - t_ap;
      gh = hg;
      `CHK("wide bytes", 2, nap)
      `CHK("second byte", 1'b1, nbh > 0)
      `CHK("strobe", 2, t_sf - t_sr)
      xfer(cfg(0, 0, 1, PMC_PM_MASTER2, 3, 2, 2));
      `CHK("setup", gs + 3, t_sr - t_ap)
      `CHK("strobe", 3, t_sf - t_sr)
      `CHK("hold", gh + 2, hg)
      xfer(cfg(0, 0, 1, PMC_PM_MASTER1, 3, 0, 3));
      `CHK("no setup", gs - 1, t_sr - t_ap)
      `CHK("one strobe", 1, t_sf - t_sr)
      `CHK("no hold", gh - 1, hg)
      xfer(cfg(0, 0, 0, PMC_PM_MASTER1, 3, 15, 3));
      `CHK("busy bit", 1'b1, bw[15])
      `CHK("narrow bytes", 1, nap)
      `CHK("high byte", 0, nbh)
      `CHK("longest strobe", 16, t_sf - t_sr)
   endtask
   task automatic t_steps();
      logic [10:0] ea;
      logic [1:0]  st;
      ea = 11'h000;
      for (int i = 0; i < 4; i++) begin
         st = (i == 3) ? 2'h2 : i[1:0];
         xfer(cfg(st, st, 1, PMC_PM_MASTER1, 0, 1, 0));
         ea = (st == 2'h1) ? ea + 11'h001 : (st == 2'h2) ? ea - 11'h001 : ea;
         `CHK("address", ea, port_address_r)
         `CHK("cycle irq", st == 2'h1, nirq > 0)
         `CHK("stall", st == 2'h2, nstall > 0)
      end
   endtask
   task automatic t_slave();
      xfer(cfg(PMC_IRQ_BUF3, PMC_STEP_BUF, 0, PMC_PM_LEGACY, 0, 1, 0));
      `CHK("slave busy", 1'b0, bw[15])
      `CHK("slave no cycle", 0, nap)
      i_pmc_host_model.access(PMC_BUF3_ADDR, 0);
      repeat (4) @(posedge core_clk);
      `CHK("buffer 3 irq", 1, nirq)
      `CHK("buffer step", 1, nbs)
      i_pmc_host_model.access(2'h2, 3);
      repeat (4) @(posedge core_clk);
      `CHK("other buffer", 1, nirq)
      `CHK("buffer step", 2, nbs)
      axw(PMC_MODE_OFS, {16'h0, cfg(PMC_IRQ_BUF3, 0, 0, PMC_PM_ENH, 0, 1, 0)}, 4'h3);
      i_pmc_host_model.access(PMC_BUF3_ADDR, 1);
      repeat (4) @(posedge core_clk);
      `CHK("address 3 irq", 2, nirq)
      `CHK("no step", 2, nbs)
      `CHK("address kept", 11'h7FF, port_address_r)
   endtask
   initial begin
      {core_clk, reset_n, sq, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_regs();
      t_timing();
      t_steps();
      t_slave();
      finish_test();
   end
endmodule

// >>> core/pmc_cycle_timer.sv
// cycle timer for one port transfer: setup, strobe and hold phases
// assumes mode fields are stable while a transfer is under way
module pmc_cycle_timer
   import pmc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // timing fields
   input  wire logic [1:0]  setup_wait_field,
   input  wire logic [3:0]  strobe_wait_field,
   input  wire logic [1:0]  hold_wait_field,
   // control
   input  wire logic        start,
   output logic             busy,
   output logic             strobe_on,
   output logic             done
);
   pmc_phase_t  phase_r;
   logic [3:0]  cnt_r;
   logic        skip_waits;

   // zero strobe wait drops the setup and hold phases entirely
   assign skip_waits = (strobe_wait_field == 4'h0);
   assign busy       = (phase_r != PMC_IDLE);
   assign strobe_on  = (phase_r == PMC_STROBE);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_r <= PMC_IDLE;
         cnt_r   <= 4'h0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         case (phase_r)
            PMC_IDLE: begin
               if (start) begin
                  if (skip_waits) begin
                     phase_r <= PMC_STROBE;
                     cnt_r   <= 4'h0;
                  end else begin
                     phase_r <= PMC_SETUP;
                     cnt_r   <= {2'h0, setup_wait_field};
                  end
               end
            end
            PMC_SETUP: begin
               if (cnt_r == 4'h0) begin
                  phase_r <= PMC_STROBE;
                  cnt_r   <= strobe_wait_field;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            PMC_STROBE: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (skip_waits) begin
                  phase_r <= PMC_IDLE;
                  done    <= 1'b1;
               end else begin
                  phase_r <= PMC_HOLD;
                  cnt_r   <= {2'h0, hold_wait_field};
               end
            end
            default: begin
               if (cnt_r == 4'h0) begin
                  phase_r <= PMC_IDLE;
                  done    <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
         endcase
      end
   end
endmodule

// >>> core/pmc_mode_ctrl.sv
// parallel port mode word with axi4-lite access and a transfer sequencer
// assumes the strobe/data pin engine sits outside and follows the outputs
module pmc_mode_ctrl
   import pmc_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // axi4-lite slave
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // slave-side access report from the pin engine
   input  wire logic                  slave_access,
   input  wire logic [1:0]            slave_addr,
   // port engine outputs
   output logic [1:0]                 port_mode_r,
   output logic                       master_mode_r,
   output logic                       strobe_active_r,
   output logic                       byte_high_r,
   output logic                       addr_phase_r,
   output logic [PMC_ADDR_W-1:0]      port_address_r,
   output logic                       buf_step_r,
   output logic                       irq_r,
   output logic                       cpu_stall_r
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [14:0]           mode_r;
   logic                  aw_held_r, w_held_r;
   logic [7:0]            awaddr_r;
   logic [31:0]           wdata_r;
   logic [3:0]            wstrb_r;
   logic                  start_r, second_pending_r, in_xfer_r;
   logic                  tm_busy, tm_strobe, tm_done;
   logic [15:0]           mode_word;
   logic                  wr_fire;
   logic [1:0]            irq_sel, step_sel;

   assign irq_sel   = mode_r[PMC_IRQ_LSB+1:PMC_IRQ_LSB];
   assign step_sel  = mode_r[PMC_STEP_LSB+1:PMC_STEP_LSB];
   assign mode_word = {in_xfer_r & master_mode_r, mode_r};
   assign wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid;

   function automatic logic is_master(input logic [1:0] pm);
      is_master = (pm == PMC_PM_MASTER1) || (pm == PMC_PM_MASTER2);
   endfunction

   // ------------------------------------------------------------
   // axi write path: address and data taken in either order
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= PMC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
         s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if ((awaddr_r[7:2] == PMC_MODE_OFS[7:2]) || (awaddr_r[7:2] == PMC_CMD_OFS[7:2])) begin
               s_axi_bresp <= PMC_RESP_OKAY;
            end else begin
               s_axi_bresp <= PMC_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // mode word; writes while busy are still accepted
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_r <= PMC_MODE_RST[14:0];
      end else if (wr_fire && awaddr_r[7:2] == PMC_MODE_OFS[7:2]) begin
         if (wstrb_r[0]) mode_r[7:0] <= wdata_r[7:0];
         if (wstrb_r[1]) mode_r[14:8] <= wdata_r[14:8] & PMC_WR_MASK[14:8];
      end
   end

   // ------------------------------------------------------------
   // axi read path
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= PMC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= PMC_RESP_OKAY;
            if (s_axi_araddr[7:2] == PMC_MODE_OFS[7:2]) begin
               s_axi_rdata <= {16'h0000, mode_word};
            end else if (s_axi_araddr[7:2] == PMC_STAT_OFS[7:2]) begin
               s_axi_rdata <= {16'h0000, port_address_r, 2'h0, tm_busy, in_xfer_r, irq_r};
            end else if (s_axi_araddr[7:2] == PMC_CMD_OFS[7:2]) begin
               s_axi_rdata <= 32'h0000_0000;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= PMC_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // transfer sequencer: command write in a master mode starts one data access
   // ------------------------------------------------------------
   pmc_cycle_timer u_timer (
      .core_clk          (core_clk),
      .reset_n           (reset_n),
      .setup_wait_field  (mode_r[PMC_SETUP_LSB+1:PMC_SETUP_LSB]),
      .strobe_wait_field (mode_r[PMC_STROBE_LSB+3:PMC_STROBE_LSB]),
      .hold_wait_field   (mode_r[PMC_HOLD_LSB+1:PMC_HOLD_LSB]),
      .start             (start_r),
      .busy              (tm_busy),
      .strobe_on         (tm_strobe),
      .done              (tm_done)
   );

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         start_r          <= 1'b0;
         in_xfer_r        <= 1'b0;
         second_pending_r <= 1'b0;
         byte_high_r      <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (wr_fire && awaddr_r[7:2] == PMC_CMD_OFS[7:2] && !in_xfer_r
             && is_master(mode_r[PMC_PMODE_LSB+1:PMC_PMODE_LSB])) begin
            in_xfer_r        <= 1'b1;
            start_r          <= 1'b1;
            byte_high_r      <= 1'b0;
            second_pending_r <= mode_r[PMC_WIDE_BIT];
         end else if (tm_done) begin
            if (second_pending_r) begin
               second_pending_r <= 1'b0;
               byte_high_r      <= 1'b1;
               start_r          <= 1'b1;
            end else begin
               in_xfer_r   <= 1'b0;
               // high-byte marker must not outlive the access it belongs to
               byte_high_r <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // mode outputs, address stepping and event outputs
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_mode_r     <= PMC_PM_LEGACY;
         master_mode_r   <= 1'b0;
         strobe_active_r <= 1'b0;
         addr_phase_r    <= 1'b0;
      end else begin
         port_mode_r     <= mode_r[PMC_PMODE_LSB+1:PMC_PMODE_LSB];
         master_mode_r   <= is_master(mode_r[PMC_PMODE_LSB+1:PMC_PMODE_LSB]);
         strobe_active_r <= tm_strobe;
         // address phase is a one-cycle pulse, one edge after each start_r, not the whole setup wait
         addr_phase_r    <= tm_busy && !tm_strobe && !in_xfer_r ? 1'b0 : start_r;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_address_r <= '0;
         buf_step_r     <= 1'b0;
      end else begin
         buf_step_r <= 1'b0;
         if (tm_done && !second_pending_r) begin
            case (step_sel)
               PMC_STEP_INC: port_address_r <= port_address_r + 11'h001;
               PMC_STEP_DEC: port_address_r <= port_address_r - 11'h001;
               default:      port_address_r <= port_address_r;
            endcase
         end
         // buffer stepping only means something in slave operation
         if (slave_access && step_sel == PMC_STEP_BUF && !master_mode_r) begin
            buf_step_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_r       <= 1'b0;
         cpu_stall_r <= 1'b0;
      end else begin
         irq_r <= 1'b0;
         case (irq_sel)
            PMC_IRQ_CYCLE: irq_r <= tm_done && !second_pending_r;
            PMC_IRQ_BUF3:  irq_r <= slave_access && slave_addr == PMC_BUF3_ADDR
                                    && !master_mode_r;
            default:       irq_r <= 1'b0;
         endcase
         // stall holds the processor for the whole access, pairs included
         cpu_stall_r <= (irq_sel == PMC_IRQ_STALL) && (in_xfer_r || start_r);
      end
   end
endmodule

// >>> core/pmc_pkg.sv
// package for the parallel port mode control block
// assumes a single core clock domain and an axi4-lite register bus
package pmc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0]  PMC_MODE_OFS    = 8'h00;
   localparam logic [7:0]  PMC_CMD_OFS     = 8'h04;
   localparam logic [7:0]  PMC_STAT_OFS    = 8'h08;
   localparam logic [15:0] PMC_MODE_RST    = 16'h0000;
   // ------------------------------------------------------------
   // field positions of the mode word
   // ------------------------------------------------------------
   localparam int PMC_BUSY_BIT    = 15;
   localparam int PMC_IRQ_LSB     = 13;
   localparam int PMC_STEP_LSB    = 11;
   localparam int PMC_WIDE_BIT    = 10;
   localparam int PMC_PMODE_LSB   = 8;
   localparam int PMC_SETUP_LSB   = 6;
   localparam int PMC_STROBE_LSB  = 2;
   localparam int PMC_HOLD_LSB    = 0;
   localparam logic [15:0] PMC_WR_MASK = 16'h7FFF;
   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [1:0] PMC_IRQ_NONE   = 2'h0;
   localparam logic [1:0] PMC_IRQ_CYCLE  = 2'h1;
   localparam logic [1:0] PMC_IRQ_STALL  = 2'h2;
   localparam logic [1:0] PMC_IRQ_BUF3   = 2'h3;
   localparam logic [1:0] PMC_STEP_NONE  = 2'h0;
   localparam logic [1:0] PMC_STEP_INC   = 2'h1;
   localparam logic [1:0] PMC_STEP_DEC   = 2'h2;
   localparam logic [1:0] PMC_STEP_BUF   = 2'h3;
   localparam logic [1:0] PMC_PM_LEGACY  = 2'h0;
   localparam logic [1:0] PMC_PM_ENH     = 2'h1;
   localparam logic [1:0] PMC_PM_MASTER2 = 2'h2;
   localparam logic [1:0] PMC_PM_MASTER1 = 2'h3;
   localparam logic [1:0] PMC_BUF3_ADDR  = 2'h3;
   localparam int PMC_ADDR_W = 11;
   localparam logic [1:0] PMC_RESP_OKAY  = 2'h0;
   localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {PMC_IDLE, PMC_SETUP, PMC_STROBE, PMC_HOLD} pmc_phase_t;
endpackage
